// File: hw/flash_pins_defines.vh
// Constants for the serial flash pin interface: array shape, command codes, timing counts.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef FLASH_PINS_DEFINES_VH
`define FLASH_PINS_DEFINES_VH
`define SECTOR_COUNT      32
`define PAGES_PER_SECTOR  256
`define BYTES_PER_PAGE    256
`define ADDR_BITS         21
`define CMD_WRITE_ARM     8'h06
`define CMD_WRITE_DISARM  8'h04
`define CMD_READ_STATUS   8'h05
`define CMD_WRITE_STATUS  8'h01
`define CMD_READ_DATA     8'h03
`define CMD_PAGE_PROGRAM  8'h02
`define CMD_SECTOR_ERASE  8'hD8
`define CMD_BULK_ERASE    8'hC7
`define STATUS_BUSY_BIT   0
`define STATUS_ARM_BIT    1
`define STATUS_GUARD_LSB  2
`define STATUS_LOCK_BIT   7
`define STATUS_RESET      8'h00
`define CLK_SYS_MHZ       10
`define PROGRAM_TIME_US   640
`define SECTOR_TIME_US    600000
`define BULK_TIME_US      13000000
`define PROGRAM_CYCLES    (`PROGRAM_TIME_US * `CLK_SYS_MHZ)
`define SECTOR_CYCLES     (`SECTOR_TIME_US * `CLK_SYS_MHZ)
`define BULK_CYCLES       (`BULK_TIME_US * `CLK_SYS_MHZ)
`define STATUS_TIME_US    5000
`define STATUS_CYCLES     (`STATUS_TIME_US * `CLK_SYS_MHZ)
`endif

// File: hw/pin_sync.v
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to clk_sys; output lags by two edges.
`timescale 1ns/10ps
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input  wire             clk_sys,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] pin_in,
	output reg  [WIDTH-1:0] pin_out
);
	reg [WIDTH-1:0] stage_one;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			stage_one <= INIT;
			pin_out   <= INIT;
		end else begin
			stage_one <= pin_in;
			pin_out   <= stage_one;
		end
	end
endmodule // pin_sync

// File: hw/busy_timer.v
// Countdown for the internal program, erase and status-write cycles.
// Assumes one start pulse at a time; a start while busy is ignored.
`timescale 1ns/10ps
module busy_timer #(
	parameter WIDTH = 28
) (
	input  wire             clk_sys,
	input  wire             reset_n,
	input  wire             start,
	input  wire [WIDTH-1:0] cycles,
	output reg              busy,
	output reg              done
);
	reg [WIDTH-1:0] remaining;

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			remaining <= {WIDTH{1'b0}};
			busy      <= 1'b0;
			done      <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy && start) begin
				remaining <= cycles;
				busy      <= 1'b1;
			end else if (busy) begin
				if (remaining <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					remaining <= remaining - {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // busy_timer

// File: hw/flash_pin_if.v
// Serial flash pin interface: serial shifter, command decoder and a small cycle engine.
// Assumes all pins are asynchronous to clk_sys and the serial clock is well below clk_sys/4.
`timescale 1ns/10ps
`include "flash_pins_defines.vh"
module flash_pin_if #(
	parameter SECTOR_CYCLES  = `SECTOR_CYCLES,
	parameter BULK_CYCLES    = `BULK_CYCLES,
	parameter STATUS_CYCLES  = `STATUS_CYCLES,
	parameter PROGRAM_CYCLES = `PROGRAM_CYCLES
) (
	input  wire                  clk_sys,
	input  wire                  reset_n,
	input  wire                  serial_clk,
	input  wire                  serial_in,
	input  wire                  select_n,
	input  wire                  pause_n,
	input  wire                  protect_n,
	output reg                   serial_out,
	output reg                   serial_out_en,
	output reg                   active_power,
	output reg                   mem_we,
	output reg                   mem_erase,
	output reg  [`ADDR_BITS-1:0] mem_addr,
	output reg  [7:0]            mem_wdata,
	input  wire [7:0]            mem_rdata
);
	localparam ST_CMD  = 3'd0;
	localparam ST_ADDR = 3'd1;
	localparam ST_DATA = 3'd2;
	localparam ST_READ = 3'd3;
	localparam ST_STAT = 3'd4;
	localparam ST_WSR  = 3'd5;
	localparam ST_SKIP = 3'd6;
	localparam OP_NONE = 2'd0;
	localparam OP_PROG = 2'd1;
	localparam OP_SECT = 2'd2;
	localparam OP_BULK = 2'd3;

	// A real program or erase touches the array; we expose the write strobes and leave the store outside.
	function needs_arm;
		input [7:0] code;
		begin
			needs_arm = (code == `CMD_PAGE_PROGRAM) || (code == `CMD_SECTOR_ERASE) ||
				(code == `CMD_BULK_ERASE) || (code == `CMD_WRITE_STATUS);
		end
	endfunction

	wire [3:0] pins_s;
	// Reset values match the idle pin levels: deselected, not paused, unprotected, clock low.
	// A mismatch would show up as a false edge two clocks after reset.
	pin_sync #(.WIDTH(4), .INIT(4'hE)) u_sync (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin_in  ({select_n, pause_n, protect_n, serial_clk}),
		.pin_out (pins_s)
	);
	wire [0:0] din_s;
	pin_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_d (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.pin_in  (serial_in),
		.pin_out (din_s)
	);
	wire sel_n_s   = pins_s[3];
	wire pause_n_s = pins_s[2];
	wire prot_n_s  = pins_s[1];
	wire sclk_s    = pins_s[0];

	reg        sclk_d;
	reg        sel_n_d;
	reg        armed_power;
	reg        paused;
	reg [2:0]  state;
	reg [2:0]  bit_cnt;
	reg [7:0]  shift_in;
	reg [7:0]  shift_out;
	reg [7:0]  cmd;
	reg [1:0]  addr_cnt;
	reg [8:0]  byte_cnt;
	reg [`ADDR_BITS-1:0] addr;
	reg [7:0]  status;
	reg [7:0]  status_new;
	reg        write_latch_arm;
	reg [1:0]  pend_op;
	reg        wsr_pend;
	reg        timer_start;
	reg [27:0] timer_cycles;
	reg [1:0]  warm;
	wire       busy;
	wire       busy_done;

	// Pause starts while selected with pause low and the clock low; it ends with pause high and the clock low, or on deselect.
	wire sclk_rise = sclk_s & ~sclk_d & ~paused;
	wire sclk_fall = ~sclk_s & sclk_d & ~paused;
	// The synchroniser shows its reset value for two edges, so a select held low since
	// power-up would otherwise look like a falling edge.
	wire sel_fall  = ~sel_n_s & sel_n_d & (warm == 2'd3);
	wire [7:0] byte_now = {shift_in[6:0], din_s[0]};
	wire byte_end  = sclk_rise & (bit_cnt == 3'd7) & ~sel_n_s;

	busy_timer #(.WIDTH(28)) u_timer (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.start   (timer_start),
		.cycles  (timer_cycles),
		.busy    (busy),
		.done    (busy_done)
	);

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			sclk_d          <= 1'b0;
			sel_n_d         <= 1'b1;
			warm            <= 2'd0;
			armed_power     <= 1'b0;
			paused          <= 1'b0;
			state           <= ST_CMD;
			bit_cnt         <= 3'd0;
			shift_in        <= 8'h00;
			shift_out       <= 8'h00;
			cmd             <= 8'h00;
			addr_cnt        <= 2'd0;
			byte_cnt        <= 9'd0;
			addr            <= {`ADDR_BITS{1'b0}};
			status_new      <= 8'h00;
			write_latch_arm <= 1'b0;
			pend_op         <= OP_NONE;
			wsr_pend        <= 1'b0;
			serial_out      <= 1'b0;
			serial_out_en   <= 1'b0;
			mem_we          <= 1'b0;
			mem_addr        <= {`ADDR_BITS{1'b0}};
			mem_wdata       <= 8'h00;
		end else begin
			sclk_d  <= sclk_s;
			sel_n_d <= sel_n_s;
			mem_we  <= 1'b0;
			if (warm != 2'd3)
				warm <= warm + 2'd1;
			if (sel_fall)
				armed_power <= 1'b1;
			if (sel_n_s)
				paused <= 1'b0;
			else if (!pause_n_s && sclk_s == 1'b0)
				paused <= 1'b1;
			else if (pause_n_s && sclk_s == 1'b0)
				paused <= 1'b0;
			// A frame-end request is assigned further down, so it wins over this clear.
			if (timer_start) begin
				pend_op  <= OP_NONE;
				wsr_pend <= 1'b0;
			end
			serial_out_en <= ~sel_n_s & ~paused & (state == ST_READ || state == ST_STAT);
			if (sel_n_s) begin
				// Frame end: commit what the frame ordered, only on whole bytes.
				if (!sel_n_d && bit_cnt == 3'd0 && !busy) begin
					if (state == ST_DATA && cmd == `CMD_PAGE_PROGRAM && byte_cnt != 9'd0) begin
						pend_op         <= OP_PROG;
						write_latch_arm <= 1'b0;
					end else if (state == ST_SKIP && cmd == `CMD_SECTOR_ERASE) begin
						pend_op         <= OP_SECT;
						mem_addr        <= {addr[`ADDR_BITS-1:16], 16'h0000};
						write_latch_arm <= 1'b0;
					end else if (state == ST_CMD && cmd == `CMD_BULK_ERASE) begin
						pend_op         <= OP_BULK;
						mem_addr        <= {`ADDR_BITS{1'b0}};
						write_latch_arm <= 1'b0;
					end else if (state == ST_SKIP && cmd == `CMD_WRITE_STATUS) begin
						wsr_pend        <= 1'b1;
						write_latch_arm <= 1'b0;
					end
				end
				state    <= ST_CMD;
				bit_cnt  <= 3'd0;
				cmd      <= 8'h00;
				addr_cnt <= 2'd0;
				byte_cnt <= 9'd0;
			end else begin
				if (sclk_rise) begin
					shift_in <= byte_now;
					bit_cnt  <= bit_cnt + 3'd1;
				end
				if (sclk_fall && (state == ST_READ || state == ST_STAT)) begin
					serial_out <= shift_out[7];
					shift_out  <= {shift_out[6:0], 1'b0};
				end
				if (byte_end && armed_power) begin
					case (state)
					ST_CMD: begin
						cmd <= byte_now;
						if (byte_now == `CMD_WRITE_ARM && !busy) begin
							write_latch_arm <= 1'b1;
							state           <= ST_SKIP;
						end else if (byte_now == `CMD_WRITE_DISARM && !busy) begin
							write_latch_arm <= 1'b0;
							state           <= ST_SKIP;
						end else if (byte_now == `CMD_READ_STATUS) begin
							shift_out <= {status[7:2], write_latch_arm, busy};
							state     <= ST_STAT;
						end else if (needs_arm(byte_now) && (!write_latch_arm || busy)) begin
							state <= ST_SKIP;
							cmd   <= 8'h00;
						end else if (byte_now == `CMD_WRITE_STATUS) begin
							state <= ST_WSR;
						end else if (byte_now == `CMD_BULK_ERASE) begin
							state <= ST_CMD;
						end else if (byte_now == `CMD_READ_DATA ||
							byte_now == `CMD_PAGE_PROGRAM || byte_now == `CMD_SECTOR_ERASE) begin
							state <= ST_ADDR;
						end else begin
							state <= ST_SKIP;
							cmd   <= 8'h00;
						end
					end
					ST_ADDR: begin
						addr     <= {addr[`ADDR_BITS-9:0], byte_now};
						addr_cnt <= addr_cnt + 2'd1;
						if (addr_cnt == 2'd2) begin
							if (cmd == `CMD_READ_DATA) begin
								mem_addr <= {addr[`ADDR_BITS-9:0], byte_now};
								state    <= ST_READ;
							end else if (cmd == `CMD_SECTOR_ERASE) begin
								state    <= ST_SKIP;
							end else begin
								state    <= ST_DATA;
							end
						end
					end
					ST_DATA: begin
						// Page address wraps inside the page; past 256 bytes the count holds, so every further byte lands on the start address.
						mem_we    <= 1'b1;
						mem_wdata <= byte_now;
						mem_addr  <= {addr[`ADDR_BITS-1:8], addr[7:0] + byte_cnt[7:0]};
						if (byte_cnt != 9'd256)
							byte_cnt <= byte_cnt + 9'd1;
					end
					ST_WSR: begin
						status_new <= byte_now;
						state      <= ST_SKIP;
					end
					ST_READ: begin
						mem_addr <= mem_addr + {{(`ADDR_BITS-1){1'b0}}, 1'b1};
					end
					default: state <= state;
					endcase
				end
				if (sclk_fall && bit_cnt == 3'd0 && state == ST_READ)
					shift_out <= {mem_rdata[6:0], 1'b0};
				if (sclk_fall && bit_cnt == 3'd0 && state == ST_READ)
					serial_out <= mem_rdata[7];
				if (sclk_fall && bit_cnt == 3'd0 && state == ST_STAT)
					shift_out <= {status[6:2], write_latch_arm, busy, 1'b0};
			end
		end
	end

	// The cycle engine runs on regardless of select; standby waits for it.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			status       <= `STATUS_RESET;
			timer_start  <= 1'b0;
			timer_cycles <= 28'd0;
			mem_erase    <= 1'b0;
			active_power <= 1'b0;
		end else begin
			timer_start  <= 1'b0;
			mem_erase    <= 1'b0;
			// Just-ended and pending frames count too, so no standby gap opens before busy rises.
			active_power <= ~sel_n_s | ~sel_n_d | busy | timer_start | wsr_pend |
				(pend_op != OP_NONE);
			if (!busy && !timer_start && wsr_pend) begin
				timer_start  <= 1'b1;
				timer_cycles <= STATUS_CYCLES[27:0];
				if (!(status[`STATUS_LOCK_BIT] && !prot_n_s))
					status <= {status_new[7:2], 2'b00};
			end else if (!busy && !timer_start && pend_op != OP_NONE) begin
				timer_start <= 1'b1;
				case (pend_op)
				OP_PROG: timer_cycles <= PROGRAM_CYCLES[27:0];
				OP_SECT: timer_cycles <= SECTOR_CYCLES[27:0];
				default: timer_cycles <= BULK_CYCLES[27:0];
				endcase
				mem_erase  <= (pend_op != OP_PROG);
			end
			if (busy_done)
				status[`STATUS_BUSY_BIT] <= 1'b0;
		end
	end
endmodule // flash_pin_if

// File: dv/flash_pin_if_assertions.sv
// Concurrent checks on the serial flash pin interface ports.
// Assumes mode 0 or mode 3 traffic with eight system clocks per serial clock period.
`timescale 1ns/10ps
module flash_pin_if_assertions (
	input logic clk_sys,
	input logic reset_n,
	input logic serial_clk,
	input logic select_n,
	input logic pause_n,
	input logic serial_out,
	input logic serial_out_en,
	input logic active_power,
	input logic mem_we,
	input logic mem_erase
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	a_float_deselect: assert property (select_n [*5] |-> !serial_out_en)
		else $error("output driven while deselected");
	a_select_active: assert property (!select_n [*6] |-> active_power)
		else $error("selected but not active");
	a_standby_cause: assert property ($fell(active_power) |-> $past(select_n, 3))
		else $error("standby while selected");
	a_busy_active: assert property (mem_erase |=> active_power [*8])
		else $error("standby during erase");
	a_out_after_fall: assert property (serial_out_en && $past(serial_out_en)
		&& serial_out != $past(serial_out) |-> $past(serial_clk, 6) && !$past(serial_clk, 2))
		else $error("output moved off a falling edge");
	a_pause_float: assert property ((!pause_n && !select_n && !serial_clk) [*7]
		|-> !serial_out_en)
		else $error("output driven in pause");
	a_write_on_rise: assert property (mem_we |-> $past(serial_clk, 3) && !$past(select_n, 3))
		else $error("write not after a rising edge");
	a_erase_at_end: assert property (mem_erase |-> $past(select_n, 3) && !mem_we)
		else $error("erase before frame end");
endmodule // flash_pin_if_assertions

bind flash_pin_if flash_pin_if_assertions u_flash_pin_if_assertions (.clk_sys(clk_sys),
	.reset_n(reset_n), .serial_clk(serial_clk), .select_n(select_n), .pause_n(pause_n),
	.serial_out(serial_out), .serial_out_en(serial_out_en), .active_power(active_power),
	.mem_we(mem_we), .mem_erase(mem_erase));

// File: dv/spi_master_model.sv
// Serial master model: mode 0 or mode 3 frames, eight system clocks per bit.
// Assumes its tasks are called just after a rising edge of clk_sys.
`timescale 1ns/10ps
module spi_master_model (
	input  logic clk_sys,
	output logic serial_clk,
	output logic serial_in,
	output logic select_n,
	output logic pause_n,
	input  logic serial_out
);
	logic idle = 1'b0;
	logic cpol = 1'b0;
	// Selected from power-up with no falling edge, so the first command must be ignored.
	initial begin
		serial_clk = 1'b0;
		serial_in = 1'b0;
		select_n = 1'b0;
		pause_n = 1'b1;
	end
	// A released data line keeps toggling so that a stale bit never passes for data.
	always @(posedge clk_sys) if (idle) serial_in <= ~serial_in;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic frame(input logic up);
		tick(4);
		select_n <= up;
		idle <= up;
		tick(4);
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			if (cpol)
				serial_clk <= 1'b0;
			serial_in <= tx[i];
			tick(4);
			serial_clk <= 1'b1;
			tick(4);
			rx[i] = serial_out;
			if (!cpol)
				serial_clk <= 1'b0;
		end
	endtask
	// Mode 3 idles the clock high; switch only while deselected and never before a pause.
	task automatic mode(input logic p);
		cpol = p;
		serial_clk <= p;
		tick(4);
	endtask
	// Clock pulses inside a pause are deliberate: the device has to ignore them.
	task automatic hold(input int wiggles);
		pause_n <= 1'b0;
		idle <= 1'b1;
		tick(8);
		repeat (wiggles) begin
			serial_clk <= 1'b1;
			tick(2);
			serial_clk <= 1'b0;
			tick(2);
		end
		pause_n <= 1'b1;
		idle <= 1'b0;
		tick(4);
	endtask
endmodule // spi_master_model

// File: dv/flash_pin_if_tb.sv
// Self-checking bench for the serial flash pin interface.
// Assumes the internal cycle lengths are cut to 20 system clocks.
`timescale 1ns/10ps
module flash_pin_if_tb;
	logic        clk_sys = 1'b0;
	logic        reset_n = 1'b0;
	logic        protect_n = 1'b1;
	logic        serial_clk, serial_in, select_n, pause_n, serial_out, serial_out_en;
	logic        active_power, mem_we, mem_erase, line_q;
	logic [20:0] mem_addr, a, ea;
	logic [7:0]  mem_wdata, mem_rdata, r, d0, d1;
	logic [28:0] wq[$];
	int          failures = 0, check_count = 0, erases = 0, seed = 32'hBD32B495;
	always #50 clk_sys = ~clk_sys;
	function automatic logic [7:0] pat(input logic [20:0] x);
		return x[7:0] ^ x[15:8] ^ {3'h0, x[20:16]};
	endfunction
	assign mem_rdata = pat(mem_addr);
	// No pull on the data line: a released line shows the inverse of its last bit.
	assign line_q = serial_out_en ? serial_out : ~serial_out;
	always @(posedge clk_sys) begin
		if (mem_we) wq.push_back({mem_addr, mem_wdata});
		if (mem_erase) begin
			erases++;
			ea = mem_addr;
		end
	end
	spi_master_model master (.clk_sys(clk_sys), .serial_clk(serial_clk), .serial_in(serial_in),
		.select_n(select_n), .pause_n(pause_n), .serial_out(line_q));
	flash_pin_if #(.SECTOR_CYCLES(20), .BULK_CYCLES(20), .STATUS_CYCLES(20), .PROGRAM_CYCLES(20))
		u_flash_pin_if (.clk_sys(clk_sys), .reset_n(reset_n), .serial_clk(serial_clk),
		.serial_in(serial_in), .select_n(select_n), .pause_n(pause_n), .protect_n(protect_n),
		.serial_out(serial_out), .serial_out_en(serial_out_en), .active_power(active_power),
		.mem_we(mem_we), .mem_erase(mem_erase), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic op(input logic [7:0] c, input logic [20:0] x, input int nb);
		master.frame(1'b0);
		master.xfer(c, r);
		for (int i = 2; i >= 3 - nb; i--) master.xfer(8'({3'h0, x} >> (8 * i)), r);
	endtask
	task automatic arm();
		op(8'h06, 21'h0, 0);
		master.frame(1'b1);
	endtask
	task automatic settle();
		for (int n = 0; n < 300 && active_power !== 1'b0; n++) @(posedge clk_sys);
		chk(active_power, 1'b0);
	endtask
	task automatic status(output logic [7:0] s);
		op(8'h05, 21'h0, 0);
		master.xfer(8'h00, s);
		master.frame(1'b1);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		master.xfer(8'h06, r);
		master.frame(1'b1);
		op(8'h02, 21'h0, 3);
		master.xfer(8'h5A, r);
		master.frame(1'b1);
		status(r);
		chk(r[1], 1'b0);
		chk(wq.size(), 0);
		for (int k = 0; k < 3; k++) begin
			a = 21'($random(seed));
			if (k == 0) a[7:0] = 8'hFF;
			d0 = 8'($random(seed));
			d1 = 8'($random(seed));
			wq.delete();
			arm();
			op(8'h02, a, 3);
			master.xfer(d0, r);
			master.xfer(d1, r);
			master.frame(1'b1);
			chk(active_power, 1'b1);
			settle();
			chk(wq.size(), 2);
			chk(wq[0], {a, d0});
			chk(wq[1], {a[20:8], 8'(a[7:0] + 8'h01), d1});
		end
		arm();
		op(8'hD8, a, 3);
		master.frame(1'b1);
		settle();
		chk(ea, {a[20:16], 16'h0000});
		arm();
		op(8'hC7, 21'h0, 0);
		master.frame(1'b1);
		settle();
		chk(ea, 21'h0);
		chk(erases, 2);
		for (int k = 0; k < 2; k++) begin
			a = 21'($random(seed)) & 21'h1FFF7F;
			op(8'h03, a, 3);
			master.hold(3);
			master.xfer(8'($random(seed)), d0);
			master.hold(0);
			master.xfer(8'($random(seed)), d1);
			master.frame(1'b1);
			chk(d0, pat(a));
			chk(d1, pat(a + 21'h1));
			chk(serial_out_en, 1'b0);
		end
		master.mode(1'b1);
		arm();
		op(8'h01, 21'h0, 0);
		master.xfer(8'h9C, r);
		master.frame(1'b1);
		settle();
		protect_n <= 1'b0;
		arm();
		op(8'h01, 21'h0, 0);
		master.xfer(8'h80, r);
		master.frame(1'b1);
		settle();
		status(r);
		chk(r[7:2], 6'h27);
		arm();
		status(r);
		chk(r[1], 1'b1);
		op(8'h04, 21'h0, 0);
		master.frame(1'b1);
		wq.delete();
		op(8'h02, a, 3);
		master.xfer(d0, r);
		master.frame(1'b1);
		status(r);
		chk(r[1], 1'b0);
		chk(wq.size(), 0);
		summarize();
	end
	initial begin
		repeat (40000) @(posedge clk_sys);
		failures++;
		summarize();
	end
endmodule // flash_pin_if_tb
